// ==== design/power_switch_test_regs.sv ====
// Register side of the external power-switch self-test, AXI4-Lite slave.
// Assumes a step sequencer on clk consumes the start, abort, type and drive outputs.
//
// Overview of operation
// - Start requests ignored while test is disarmed
// - Disarming during a run aborts it at once
// - Armed device accepts a sequence start request
// - Manual and resistor bits locked, cleared when disarmed
// - High-side forced values at bits 10, 6, 2
// - Low-side forced values at bits 8, 4, 0
// - Both sides on drives the phase off
// - Status bit 5 shows sequence running
// - Status bit 4 flags mismatch, types A-C
// - Status field holds last or mismatching step
// - Select 0 reads saved comparator values
// - Select 1 reads live comparator values
// - Arm register written at 60h, read E0h
// - Scratch register at 7Ch and FCh stores value
// - Start needs arming and reads back zero
// - Two-bit type field selects A, B, C, D
// - Stop beats a simultaneous start request
// - Saved-result clear wipes captures and mismatch flag
//
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none
module power_switch_test_regs
	import pst_pkg::*;
#(
	parameter int ADDR_W = 8
)
(
	// Clock and reset
	input  wire logic                           clk,
	input  wire logic                           sys_rst,
	// AXI4-Lite slave
	input  wire logic [ADDR_W-1:0]              s_axi_awaddr,
	input  wire logic                           s_axi_awvalid,
	output logic                                s_axi_awready,
	input  wire logic [31:0]                    s_axi_wdata,
	input  wire logic [3:0]                     s_axi_wstrb,
	input  wire logic                           s_axi_wvalid,
	output logic                                s_axi_wready,
	output logic [1:0]                          s_axi_bresp,
	output logic                                s_axi_bvalid,
	input  wire logic                           s_axi_bready,
	input  wire logic [ADDR_W-1:0]              s_axi_araddr,
	input  wire logic                           s_axi_arvalid,
	output logic                                s_axi_arready,
	output logic [31:0]                         s_axi_rdata,
	output logic [1:0]                          s_axi_rresp,
	output logic                                s_axi_rvalid,
	input  wire logic                           s_axi_rready,
	// Sequencer control
	output logic                                seq_start,
	output logic                                seq_abort,
	output pst_pkg::test_type_t                 seq_type,
	input  wire logic                           seq_done,
	input  wire logic                           seq_step_valid,
	input  wire logic [2:0]                     seq_step,
	input  wire logic                           seq_mismatch,
	input  wire logic                           seq_capture,
	input  wire logic [pst_pkg::NUM_GATES-1:0]  seq_capture_cmp,
	input  wire logic [pst_pkg::NUM_GATES-1:0]  live_cmp,
	// Test mode outputs
	output logic                                manual_cmp_mode,
	output logic                                mid_resistor_u_on,
	output logic                                mid_resistor_v_on,
	output logic                                mid_resistor_w_on,
	output logic [2:0]                          forced_high,
	output logic [2:0]                          forced_low
);
	import pst_pkg::*;

	if (ADDR_W < MIN_ADDR_W)
	begin : g_bad_addr_w
		$error("ADDR_W too small for the register map");
	end

	logic                  aw_held, next_aw_held;
	logic [ADDR_W-1:0]     awaddr_q, next_awaddr_q;
	logic                  w_held, next_w_held;
	logic [31:0]           wdata_q, next_wdata_q;
	logic [3:0]            wstrb_q, next_wstrb_q;
	logic                  bvalid, next_bvalid;
	logic [1:0]            bresp, next_bresp;
	logic                  rvalid, next_rvalid;
	logic [31:0]           rdata, next_rdata;
	logic [1:0]            rresp, next_rresp;
	logic [REG_W-1:0]      arm_reg, next_arm_reg;
	logic                  manual, next_manual;
	logic [2:0]            rmid, next_rmid;
	logic                  cmp_sel, next_cmp_sel;
	test_type_t            test_type, next_test_type;
	logic [REG_W-1:0]      scratch_bits, next_scratch_bits;
	seq_state_t            state, next_state;
	logic                  err, next_err;
	logic [2:0]            last_step_index, next_last_step_index;
	logic [NUM_GATES-1:0]  saved_cmp, next_saved_cmp;
	logic                  start_pulse, next_start_pulse;
	logic                  abort_pulse, next_abort_pulse;
	logic                  wr_fire, rd_fire;
	logic                  start_req, stop_req, clear_req, disarm_now;
	logic [REG_W-1:0]      ctrl_word, stat_word, cmp_word, rd_word;
	logic [NUM_GATES-1:0]  cmp_view;

	function automatic logic [REG_W-1:0] merge16(input logic [REG_W-1:0] old,
		input logic [31:0] d, input logic [3:0] s);
		merge16 = old;
		if (s[0])
			merge16[7:0] = d[7:0];
		if (s[1])
			merge16[15:8] = d[15:8];
	endfunction : merge16

	function automatic logic addr_is(input logic [ADDR_W-1:0] a, input logic [7:0] r);
		addr_is = (a == ADDR_W'(r));
	endfunction : addr_is

	assign s_axi_awready = ~aw_held & ~bvalid;
	assign s_axi_wready  = ~w_held & ~bvalid;
	assign s_axi_arready = ~rvalid;
	assign wr_fire       = aw_held & w_held & ~bvalid;
	assign rd_fire       = s_axi_arvalid & ~rvalid;

	// Read views
	always_comb
	begin
		cmp_view  = cmp_sel ? live_cmp : saved_cmp;
		ctrl_word = REG_RESET;
		ctrl_word[CTL_MANUAL] = manual;
		ctrl_word[CTL_RMID_W +: 3] = rmid;
		ctrl_word[CTL_CMP_SEL] = cmp_sel;
		ctrl_word[CTL_TYPE_LO +: 2] = test_type;
		stat_word = REG_RESET;
		stat_word[STAT_RUN] = (state == SEQ_RUN);
		stat_word[STAT_ERR] = err;
		stat_word[2:0] = last_step_index;
		cmp_word = REG_RESET;
		for (int i = 0; i < NUM_GATES; i++)
			cmp_word[GATE_STRIDE*i] = cmp_view[i];
		if (addr_is(s_axi_araddr, ADDR_CTRL_RD))
			rd_word = ctrl_word;
		else if (addr_is(s_axi_araddr, ADDR_ARM_RD))
			rd_word = arm_reg;
		else if (addr_is(s_axi_araddr, ADDR_STAT_RD))
			rd_word = stat_word;
		else if (addr_is(s_axi_araddr, ADDR_CMP_RD))
			rd_word = cmp_word;
		else if (addr_is(s_axi_araddr, ADDR_SCR_RD))
			rd_word = scratch_bits;
		else
			rd_word = REG_RESET;
	end

	// Bus slave and register writes
	always_comb
	begin
		next_aw_held = aw_held;
		next_awaddr_q = awaddr_q;
		next_w_held = w_held;
		next_wdata_q = wdata_q;
		next_wstrb_q = wstrb_q;
		next_bvalid = bvalid & ~s_axi_bready;
		next_bresp = bresp;
		next_rvalid = rvalid & ~s_axi_rready;
		next_rdata = rdata;
		next_rresp = rresp;
		next_arm_reg = arm_reg;
		next_manual = manual;
		next_rmid = rmid;
		next_cmp_sel = cmp_sel;
		next_test_type = test_type;
		next_scratch_bits = scratch_bits;
		start_req = 1'b0;
		stop_req = 1'b0;
		clear_req = 1'b0;
		if (s_axi_awvalid && s_axi_awready)
		begin
			next_aw_held = 1'b1;
			next_awaddr_q = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			next_w_held = 1'b1;
			next_wdata_q = s_axi_wdata;
			next_wstrb_q = s_axi_wstrb;
		end
		if (wr_fire)
		begin
			next_aw_held = 1'b0;
			next_w_held = 1'b0;
			next_bvalid = 1'b1;
			next_bresp = RESP_OKAY;
			if (addr_is(awaddr_q, ADDR_ARM_WR))
				next_arm_reg = merge16(arm_reg, wdata_q, wstrb_q) & ARM_MASK;
			else if (addr_is(awaddr_q, ADDR_SCR_WR))
				next_scratch_bits = merge16(scratch_bits, wdata_q, wstrb_q);
			else if (addr_is(awaddr_q, ADDR_CTRL_WR))
			begin
				if (wstrb_q[0])
				begin
					// Start, stop and clear are pulses and never stored
					start_req = wdata_q[CTL_START];
					stop_req = wdata_q[CTL_STOP];
					clear_req = wdata_q[CTL_SAVE_CLR];
					next_cmp_sel = wdata_q[CTL_CMP_SEL];
					next_test_type = test_type_t'(wdata_q[CTL_TYPE_LO +: 2]);
				end
				if (wstrb_q[1] && arm_reg[ARM_BIT])
				begin
					next_manual = wdata_q[CTL_MANUAL];
					next_rmid = wdata_q[CTL_RMID_W +: 3];
				end
			end
			else
				next_bresp = RESP_SLVERR;
		end
		disarm_now = ~next_arm_reg[ARM_BIT];
		if (disarm_now)
		begin
			next_manual = 1'b0;
			next_rmid = 3'h0;
		end
		if (rd_fire)
		begin
			next_rvalid = 1'b1;
			next_rdata = {16'h0000, rd_word};
			if (addr_is(s_axi_araddr, ADDR_CTRL_RD) || addr_is(s_axi_araddr, ADDR_ARM_RD)
				|| addr_is(s_axi_araddr, ADDR_STAT_RD) || addr_is(s_axi_araddr, ADDR_CMP_RD)
				|| addr_is(s_axi_araddr, ADDR_SCR_RD))
				next_rresp = RESP_OKAY;
			else
				next_rresp = RESP_SLVERR;
		end
	end

	// Sequence run state and results
	always_comb
	begin
		next_state = state;
		next_start_pulse = 1'b0;
		next_abort_pulse = 1'b0;
		next_err = err;
		next_last_step_index = last_step_index;
		next_saved_cmp = saved_cmp;
		case (state)
			SEQ_IDLE:
			begin
				if (start_req && !stop_req && arm_reg[ARM_BIT])
				begin
					next_state = SEQ_RUN;
					next_start_pulse = 1'b1;
					next_last_step_index = 3'h0;
				end
			end
			SEQ_RUN:
			begin
				if (stop_req || disarm_now)
				begin
					next_state = SEQ_IDLE;
					next_abort_pulse = 1'b1;
				end
				else if (seq_done)
					next_state = SEQ_IDLE;
			end
			default:
				next_state = SEQ_IDLE;
		endcase
		if (clear_req)
		begin
			next_err = 1'b0;
			next_saved_cmp = '0;
		end
		if (state == SEQ_RUN)
		begin
			if (seq_capture)
				next_saved_cmp = seq_capture_cmp;
			// A captured mismatch freezes the step number until a saved-result clear; a later mismatch or an accepted start overwrites it
			if (seq_mismatch && test_type != TYPE_D)
			begin
				next_err = 1'b1;
				next_last_step_index = seq_step;
			end
			else if (seq_step_valid && !err)
				next_last_step_index = seq_step;
		end
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			aw_held <= 1'b0;
			awaddr_q <= '0;
			w_held <= 1'b0;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
			bvalid <= 1'b0;
			bresp <= RESP_OKAY;
			rvalid <= 1'b0;
			rdata <= 32'h0000_0000;
			rresp <= RESP_OKAY;
			arm_reg <= REG_RESET;
			manual <= 1'b0;
			rmid <= 3'h0;
			cmp_sel <= 1'b0;
			test_type <= TYPE_A;
			scratch_bits <= REG_RESET;
			state <= SEQ_IDLE;
			err <= 1'b0;
			last_step_index <= 3'h0;
			saved_cmp <= '0;
			start_pulse <= 1'b0;
			abort_pulse <= 1'b0;
		end
		else
		begin
			aw_held <= next_aw_held;
			awaddr_q <= next_awaddr_q;
			w_held <= next_w_held;
			wdata_q <= next_wdata_q;
			wstrb_q <= next_wstrb_q;
			bvalid <= next_bvalid;
			bresp <= next_bresp;
			rvalid <= next_rvalid;
			rdata <= next_rdata;
			rresp <= next_rresp;
			arm_reg <= next_arm_reg;
			manual <= next_manual;
			rmid <= next_rmid;
			cmp_sel <= next_cmp_sel;
			test_type <= next_test_type;
			scratch_bits <= next_scratch_bits;
			state <= next_state;
			err <= next_err;
			last_step_index <= next_last_step_index;
			saved_cmp <= next_saved_cmp;
			start_pulse <= next_start_pulse;
			abort_pulse <= next_abort_pulse;
		end
	end

	phase_drive_if drv [3] ();

	for (genvar p = 0; p < 3; p++)
	begin : g_phase
		// Phase 2 is U, 1 is V, 0 is W
		assign drv[p].hs_req = arm_reg[GATE_STRIDE*(2*p+1)];
		assign drv[p].ls_req = arm_reg[GATE_STRIDE*(2*p)];
		assign forced_high[p] = drv[p].hs_out;
		assign forced_low[p] = drv[p].ls_out;
		phase_guard u_guard (
			.clk     (clk),
			.sys_rst (sys_rst),
			.drv     (drv[p])
		);
	end

	assign s_axi_bvalid = bvalid;
	assign s_axi_bresp = bresp;
	assign s_axi_rvalid = rvalid;
	assign s_axi_rdata = rdata;
	assign s_axi_rresp = rresp;
	assign seq_start = start_pulse;
	assign seq_abort = abort_pulse;
	assign seq_type = test_type;
	assign manual_cmp_mode = manual;
	assign {mid_resistor_u_on, mid_resistor_v_on, mid_resistor_w_on} = rmid;

	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	sequence s_disarm_in_run;
		(state == SEQ_RUN) && wr_fire && disarm_now;
	endsequence
	sequence s_aborted;
		(state == SEQ_IDLE) && seq_abort;
	endsequence

	property p_start_needs_arm;
		seq_start |-> $past(arm_reg[ARM_BIT]);
	endproperty
	a_start_needs_arm: assert property (p_start_needs_arm)
		else $error("sequence started while disarmed");
	property p_disarm_aborts;
		s_disarm_in_run |=> s_aborted;
	endproperty
	a_disarm_aborts: assert property (p_disarm_aborts)
		else $error("disarm did not abort the sequence");
	property p_start_accepted;
		(state == SEQ_IDLE && start_req && !stop_req && arm_reg[ARM_BIT])
			|=> seq_start && stat_word[STAT_RUN];
	endproperty
	a_start_accepted: assert property (p_start_accepted)
		else $error("armed start not accepted");
	property p_locked_when_disarmed;
		!arm_reg[ARM_BIT] |-> (!manual_cmp_mode && rmid == 3'h0);
	endproperty
	a_locked_when_disarmed: assert property (p_locked_when_disarmed)
		else $error("manual or resistor bit set while disarmed");
	property p_high_map;
		forced_high[2] == $past(arm_reg[10] & ~arm_reg[8]);
	endproperty
	a_high_map: assert property (p_high_map)
		else $error("U high-side drive not from bit 10");
	property p_low_map;
		forced_low[0] == $past(arm_reg[0] & ~arm_reg[2]);
	endproperty
	a_low_map: assert property (p_low_map)
		else $error("W low-side drive not from bit 0");
	property p_mismatch_flag;
		(state == SEQ_RUN && seq_mismatch && test_type != TYPE_D)
			|=> stat_word[STAT_ERR] && last_step_index == $past(seq_step);
	endproperty
	a_mismatch_flag: assert property (p_mismatch_flag)
		else $error("mismatch not recorded");
	property p_stop_wins;
		(start_req && stop_req) |=> !seq_start;
	endproperty
	a_stop_wins: assert property (p_stop_wins)
		else $error("start taken alongside stop");
	property p_done_drops_run;
		(state == SEQ_RUN && seq_done) |=> !stat_word[STAT_RUN] && !seq_start;
	endproperty
	a_done_drops_run: assert property (p_done_drops_run)
		else $error("running flag held after completion");
	property p_clear_err;
		(clear_req && !(state == SEQ_RUN && seq_mismatch)) |=> !err;
	endproperty
	a_clear_err: assert property (p_clear_err)
		else $error("saved-result clear left mismatch flag");
endmodule : power_switch_test_regs
`default_nettype wire

// ==== design/pst_pkg.sv ====
// Constants and types for the power-switch self-test register block.
// Assumes AXI4-Lite byte addresses with the registers in the low 256 bytes.
package pst_pkg;
	localparam int          REG_W        = 16;
	localparam int          NUM_GATES    = 6;
	localparam int          GATE_STRIDE  = 2;
	localparam int          MIN_ADDR_W   = 8;
	// Byte addresses: write ports and read ports are separate
	localparam logic [7:0]  ADDR_CTRL_WR = 8'h5c;
	localparam logic [7:0]  ADDR_CTRL_RD = 8'hdc;
	localparam logic [7:0]  ADDR_ARM_WR  = 8'h60;
	localparam logic [7:0]  ADDR_ARM_RD  = 8'he0;
	localparam logic [7:0]  ADDR_STAT_RD = 8'he4;
	localparam logic [7:0]  ADDR_CMP_RD  = 8'he8;
	localparam logic [7:0]  ADDR_SCR_WR  = 8'h7c;
	localparam logic [7:0]  ADDR_SCR_RD  = 8'hfc;
	// Arm and forced-drive register
	localparam int          ARM_BIT      = 12;
	localparam logic [15:0] ARM_MASK     = 16'h1555;
	// Control register fields
	localparam int          CTL_MANUAL   = 11;
	localparam int          CTL_RMID_W   = 8;
	localparam int          CTL_SAVE_CLR = 7;
	localparam int          CTL_CMP_SEL  = 4;
	localparam int          CTL_TYPE_LO  = 2;
	localparam int          CTL_START    = 1;
	localparam int          CTL_STOP     = 0;
	// Status register fields
	localparam int          STAT_RUN     = 5;
	localparam int          STAT_ERR     = 4;
	localparam logic [15:0] REG_RESET    = 16'h0000;
	localparam logic [1:0]  RESP_OKAY    = 2'b00;
	localparam logic [1:0]  RESP_SLVERR  = 2'b10;

	typedef enum logic [1:0] {TYPE_A, TYPE_B, TYPE_C, TYPE_D} test_type_t;
	typedef enum logic {SEQ_IDLE, SEQ_RUN} seq_state_t;
endpackage : pst_pkg

// ==== design/phase_drive_if.sv ====
// Requested and guarded gate drive values of one motor phase.
// Assumes the owner drives the requests and one phase_guard drives the outputs.
`timescale 1ns/100ps
`default_nettype none
interface phase_drive_if;
	logic hs_req;
	logic ls_req;
	logic hs_out;
	logic ls_out;
	modport guard (input hs_req, input ls_req, output hs_out, output ls_out);
	modport owner (output hs_req, output ls_req, input hs_out, input ls_out);
endinterface : phase_drive_if
`default_nettype wire

// ==== design/phase_guard.sv ====
// Shoot-through guard for the forced drive values of one phase.
// Assumes requests come from logic on clk.
`timescale 1ns/100ps
`default_nettype none
module phase_guard
(
	// Clock and reset
	input  wire logic    clk,
	input  wire logic    sys_rst,
	// Drive values
	phase_drive_if.guard drv
);
	logic hs;
	logic ls;
	logic next_hs;
	logic next_ls;

	always_comb
	begin
		// Both sides on turns the phase fully off
		next_hs = drv.hs_req & ~drv.ls_req;
		next_ls = drv.ls_req & ~drv.hs_req;
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			hs <= 1'b0;
			ls <= 1'b0;
		end
		else
		begin
			hs <= next_hs;
			ls <= next_ls;
		end
	end

	assign drv.hs_out = hs;
	assign drv.ls_out = ls;

	property p_no_shoot_through;
		@(posedge clk) disable iff (sys_rst)
		(drv.hs_req && drv.ls_req) |=> (!drv.hs_out && !drv.ls_out);
	endproperty
	a_no_shoot_through: assert property (p_no_shoot_through)
		else $error("both gates of one phase driven");
endmodule : phase_guard
`default_nettype wire

// ==== testbench/seq_model.sv ====
// Behavioural step sequencer that answers the register block's start and abort pulses.
// Assumes the bench sets the pacing, the mismatching step and the captured comparator word.
`timescale 1ns/100ps
`default_nettype none
module seq_model
(
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       sys_rst,
	// From the register block
	input  wire logic       seq_start,
	input  wire logic       seq_abort,
	// Pacing and outcome chosen by the bench
	input  wire logic [7:0] hold,
	input  wire logic       mis_en,
	input  wire logic [2:0] mis_step,
	input  wire logic [5:0] cap_val,
	// To the register block
	output logic            seq_done,
	output logic            seq_step_valid,
	output logic [2:0]      seq_step,
	output logic            seq_mismatch,
	output logic            seq_capture,
	output logic [5:0]      seq_capture_cmp
);
	logic       active;
	logic [7:0] cnt;
	logic [7:0] rel;

	always @(posedge clk)
	begin
		rel = cnt - hold;
		seq_done       <= 1'b0;
		seq_step_valid <= 1'b0;
		seq_mismatch   <= 1'b0;
		seq_capture    <= 1'b0;
		// Step and capture lines carry nothing between pulses, so they keep toggling
		seq_step        <= ~seq_step;
		seq_capture_cmp <= ~seq_capture_cmp;
		if (sys_rst)
		begin
			active          <= 1'b0;
			seq_step        <= 3'h0;
			seq_capture_cmp <= 6'h00;
		end
		else if (seq_abort)
			active <= 1'b0;
		else if (seq_start)
		begin
			active <= 1'b1;
			cnt    <= 8'h00;
		end
		else if (active)
		begin
			cnt <= cnt + 8'h01;
			if (cnt >= hold && rel < 8'h04)
			begin
				seq_step_valid <= 1'b1;
				seq_step       <= rel[2:0];
				seq_mismatch   <= mis_en && rel[2:0] == mis_step;
				seq_capture    <= rel == 8'h03;
				if (rel == 8'h03)
					seq_capture_cmp <= cap_val;
			end
			if (cnt >= hold && rel == 8'h04)
			begin
				seq_done <= 1'b1;
				active   <= 1'b0;
			end
		end
	end
endmodule : seq_model
`default_nettype wire

// ==== testbench/test_power_switch_test_regs.sv ====
// Self-checking bench for the power-switch self-test register block.
// Assumes pst_pkg, the design files and seq_model are compiled before it.
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin bad_count++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module test_power_switch_test_regs;
	import pst_pkg::*;
	logic clk, sys_rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [7:0] s_axi_awaddr, s_axi_araddr, hold;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, ty;
	logic seq_start, seq_abort, seq_done, seq_step_valid, seq_mismatch, seq_capture, mis_en;
	logic [2:0] seq_step, mis_step, forced_high, forced_low;
	logic [5:0] seq_capture_cmp, live_cmp, cap_val;
	logic manual_cmp_mode, mid_resistor_u_on, mid_resistor_v_on, mid_resistor_w_on;
	test_type_t seq_type;
	logic [15:0] v;
	logic [5:0] g;
	logic [31:0] d;
	logic [1:0] r;
	int bad_count, comparisons, starts, aborts, a0, s0, i;

	power_switch_test_regs #(.ADDR_W(8)) dut (.clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .seq_start, .seq_abort, .seq_type, .seq_done,
		.seq_step_valid, .seq_step, .seq_mismatch, .seq_capture, .seq_capture_cmp, .live_cmp,
		.manual_cmp_mode, .mid_resistor_u_on, .mid_resistor_v_on, .mid_resistor_w_on,
		.forced_high, .forced_low);
	seq_model seq (.clk, .sys_rst, .seq_start, .seq_abort, .hold, .mis_en, .mis_step, .cap_val,
		.seq_done, .seq_step_valid, .seq_step, .seq_mismatch, .seq_capture, .seq_capture_cmp);

	always #2.5 clk = ~clk;

	always @(posedge clk)
	begin
		if (seq_start === 1'b1) starts++;
		if (seq_abort === 1'b1) aborts++;
	end

	function automatic logic [15:0] spread(input logic [5:0] c);
		logic [15:0] s;
		s = 16'h0000;
		for (int k = 0; k < 6; k++) s[2*k] = c[k];
		return s;
	endfunction : spread

	// Guarded drive: a phase asked for both sides gets neither
	function automatic logic [5:0] guarded(input logic [15:0] a);
		logic [2:0] h, l;
		h = {a[10], a[6], a[2]};
		l = {a[8], a[4], a[0]};
		return {h & ~l, l & ~h};
	endfunction : guarded

	task automatic end_sim;
		$display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : end_sim

	task automatic axi_wr(input logic [7:0] a, input logic [15:0] wd, output logic [1:0] wr_r);
		logic ta, tw, tb;
		@(posedge clk);
		s_axi_awaddr  <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata   <= {16'h0000, wd};
		s_axi_wvalid  <= 1'b1;
		s_axi_bready  <= 1'b1;
		tb = 1'b0;
		for (int n = 0; n < 64 && !tb; n++)
		begin
			@(negedge clk);
			ta = s_axi_awvalid && s_axi_awready;
			tw = s_axi_wvalid && s_axi_wready;
			tb = s_axi_bvalid;
			wr_r = s_axi_bresp;
			@(posedge clk);
			if (ta) s_axi_awvalid <= 1'b0;
			if (tw) s_axi_wvalid <= 1'b0;
			if (tb) s_axi_bready <= 1'b0;
		end
		if (!tb) begin bad_count++; end_sim(); end
	endtask : axi_wr

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] rd, output logic [1:0] rd_r);
		logic ta, tr;
		@(posedge clk);
		s_axi_araddr  <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready  <= 1'b1;
		tr = 1'b0;
		for (int n = 0; n < 64 && !tr; n++)
		begin
			@(negedge clk);
			ta = s_axi_arvalid && s_axi_arready;
			tr = s_axi_rvalid;
			rd = s_axi_rdata;
			rd_r = s_axi_rresp;
			@(posedge clk);
			if (ta) s_axi_arvalid <= 1'b0;
			if (tr) s_axi_rready <= 1'b0;
		end
		if (!tr) begin bad_count++; end_sim(); end
	endtask : axi_rd

	task automatic wr(input logic [7:0] a, input logic [15:0] wd);
		logic [1:0] wr_r;
		axi_wr(a, wd, wr_r);
		`CHK(wr_r, RESP_OKAY)
		@(negedge clk);
	endtask : wr

	task automatic chk_rd(input logic [7:0] a, input logic [15:0] e);
		logic [31:0] rd;
		logic [1:0]  rd_r;
		axi_rd(a, rd, rd_r);
		`CHK({rd_r, rd}, {RESP_OKAY, 16'h0000, e})
	endtask : chk_rd

	initial
	begin
		clk = 0; sys_rst = 1; s_axi_awaddr = 0; s_axi_awvalid = 0; s_axi_wdata = 0;
		s_axi_wstrb = 4'hf; s_axi_wvalid = 0; s_axi_bready = 0; s_axi_araddr = 0;
		s_axi_arvalid = 0; s_axi_rready = 0; live_cmp = 0; cap_val = 0;
		hold = 8'h1e; mis_en = 1; mis_step = 3'h2;
		void'($urandom(27407));
		repeat (8) @(posedge clk);
		sys_rst <= 1'b0;
		chk_rd(ADDR_ARM_RD, 16'h0000);
		chk_rd(ADDR_STAT_RD, 16'h0000);
		chk_rd(ADDR_CMP_RD, 16'h0000);
		chk_rd(ADDR_SCR_RD, 16'h0000);
		`CHK({forced_high, forced_low, manual_cmp_mode}, 7'h00)
		`CHK({seq_start, seq_abort, seq_type}, 4'h0)
		axi_rd(8'h40, d, r);
		`CHK({r, d}, {RESP_SLVERR, 32'h0})
		for (i = 0; i < 4; i++)
		begin
			v = (i == 0) ? 16'hffff : 16'($urandom);
			wr(ADDR_SCR_WR, v);
			chk_rd(ADDR_SCR_RD, v);
		end
		// Disarmed: start and lock bits refused
		wr(ADDR_CTRL_WR, 16'h0f02);
		`CHK(starts, 0)
		`CHK({manual_cmp_mode, mid_resistor_u_on, mid_resistor_v_on, mid_resistor_w_on}, 4'h0)
		chk_rd(ADDR_CTRL_RD, 16'h0000);
		chk_rd(ADDR_STAT_RD, 16'h0000);
		for (i = 0; i < 6; i++)
		begin
			v = (i == 0) ? 16'h1555 : (16'($urandom) & ARM_MASK) | 16'h1000;
			wr(ADDR_ARM_WR, v);
			g = guarded(v);
			`CHK(forced_high, g[5:3])
			`CHK(forced_low, g[2:0])
			chk_rd(ADDR_ARM_RD, v);
		end
		axi_wr(ADDR_ARM_RD, 16'h0000, r);
		`CHK(r, RESP_SLVERR)
		chk_rd(ADDR_ARM_RD, v);
		wr(ADDR_ARM_WR, 16'h1000);
		wr(ADDR_CTRL_WR, 16'h0f03);
		`CHK(starts, 0)
		`CHK({manual_cmp_mode, mid_resistor_u_on, mid_resistor_v_on, mid_resistor_w_on}, 4'hf)
		chk_rd(ADDR_CTRL_RD, 16'h0f00);
		for (i = 0; i < 4; i++)
		begin
			ty = 2'(i);
			cap_val <= 6'($urandom);
			wr(ADDR_CTRL_WR, 16'h0f80);
			wr(ADDR_CTRL_WR, 16'h0f02 | {12'h000, ty, 2'b00});
			`CHK(starts, i + 1)
			`CHK(seq_type, test_type_t'(ty))
			chk_rd(ADDR_STAT_RD, 16'h0020);
			@(negedge clk);
			for (a0 = 0; a0 < 200 && seq_done !== 1'b1; a0++) @(negedge clk);
			if (a0 == 200) begin bad_count++; end_sim(); end
			chk_rd(ADDR_STAT_RD, (ty == 2'h3) ? 16'h0003 : 16'h0012);
			chk_rd(ADDR_CMP_RD, spread(cap_val));
			chk_rd(ADDR_CTRL_RD, 16'h0f00 | {12'h000, ty, 2'b00});
		end
		live_cmp <= 6'($urandom);
		wr(ADDR_CTRL_WR, 16'h0f90);
		chk_rd(ADDR_CMP_RD, spread(live_cmp));
		chk_rd(ADDR_STAT_RD, 16'h0003);
		wr(ADDR_CTRL_WR, 16'h0f80);
		chk_rd(ADDR_CMP_RD, 16'h0000);
		chk_rd(ADDR_CTRL_RD, 16'h0f00);
		// Stop in mid-run, then disarm in mid-run
		a0 = aborts;
		wr(ADDR_CTRL_WR, 16'h0f02);
		wr(ADDR_CTRL_WR, 16'h0f01);
		`CHK(aborts, a0 + 1)
		chk_rd(ADDR_STAT_RD, 16'h0000);
		wr(ADDR_CTRL_WR, 16'h0f02);
		wr(ADDR_ARM_WR, 16'h0000);
		`CHK(aborts, a0 + 2)
		`CHK({manual_cmp_mode, mid_resistor_u_on, mid_resistor_v_on, mid_resistor_w_on}, 4'h0)
		chk_rd(ADDR_STAT_RD, 16'h0000);
		chk_rd(ADDR_CTRL_RD, 16'h0000);
		s0 = starts;
		wr(ADDR_CTRL_WR, 16'h0002);
		`CHK(starts, s0)
		end_sim();
	end
endmodule : test_power_switch_test_regs
`default_nettype wire
